// file: pzm_defs.svh
/*
 * Register indices, field positions and reset values of port zero.
 * Assumes a 32-bit bus where the byte address is four times the index.
 */
`ifndef PZM_DEFS_SVH
`define PZM_DEFS_SVH
// Register indices, byte address is index * 4
`define PZM_IDX_DATA      8'hc0
`define PZM_IDX_DIR       8'hc1
`define PZM_IDX_OD        8'hc8
`define PZM_IDX_SER       8'he2
`define PZM_IDX_CONV      8'hef
`define PZM_IDX_ALT_A     8'hf8
`define PZM_IDX_ALT_B     8'hf9
`define PZM_IDX_PU        8'hfc
// Reset values
`define PZM_RST_DATA      8'h00
`define PZM_RST_DIR       8'h00
`define PZM_RST_OTHER     8'h00
// Select register a fields
`define PZM_A_EXT_INTERRUPT_TWO        2
`define PZM_A_EXT_INTERRUPT_THREE        3
`define PZM_A_EC0         4
`define PZM_A_EC1         5
// Select register b fields
`define PZM_B_T0O         0
`define PZM_B_T2O         1
// Converter control fields
`define PZM_CONV_EN       7
`define PZM_CONV_CH_HI    5
`define PZM_CONV_CH_LO    2
// Serial control fields
`define PZM_SER_MODE_HI   5
`define PZM_SER_MODE_LO   4
`define PZM_SER_CLK_HI    3
`define PZM_SER_CLK_LO    2
`endif

// file: pzm_pkg.sv
/*
 * Carrier types of the port zero block.
 * Assumes pzm_defs.svh supplies the numbers.
 */
package pzm_pkg;
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
    logic [7:0] ana;
  } pzm_pad_t;
  typedef struct packed {
    logic timer_a;
    logic timer_c;
    logic serial_clk;
    logic serial_data;
  } pzm_alt_out_t;
  typedef struct packed {
    logic ext_int_three;
    logic ext_int_two;
    logic event_count_a;
    logic event_count_b;
    logic serial_clk;
    logic serial_data;
  } pzm_alt_in_t;
  typedef struct packed {
    logic pwm_c_output_enable;
    logic pwm_a_output_enable;
    logic crystal_pin_enable;
    logic buzzer_output_enable;
  } pzm_far_en_t;
endpackage : pzm_pkg

// file: pzm_port.sv
/*
 * Port zero: 8-bit general purpose port with pin multiplexing, AHB-Lite slave.
 * Assumes one 50 MHz clock, pad cells that resolve o/oe/pu/ana, and
 * timer and serial units on the same clock.
 */
// Behaviour
// - Direction one drives, zero makes input
// - Reset clears all direction bits
// - Eight pins, data c0, direction c1
// - Pull-up bit applies on input pins that are not analog
// - Open-drain bit: pull low only
// - Select bit overrides direction bit
// - Select registers f8, f9 pick alternates
// - Converter/serial control take over pins
// - Pin0: interrupt three, serial clock
// - Pin1: analog one, serial data in
// - Pin2: serial data out
// - Pin3: analog three, interrupt two
// - Pin4: analog four, event count a
// - Pin5: analog five, timer a output
// - Pin6: analog six, timer c output
// - Pin7: analog seven, event count b
`timescale 1ns/1ps
`include "pzm_defs.svh"
module pzm_port
  import pzm_pkg::*;
(
  input  wire logic         SYS_CLK,
  input  wire logic         RST_B,
  input  wire logic         CE,
  input  wire logic         HSEL,
  input  wire logic [31:0]  HADDR,
  input  wire logic [1:0]   HTRANS,
  input  wire logic         HWRITE,
  input  wire logic [2:0]   HSIZE,
  input  wire logic [31:0]  HWDATA,
  input  wire logic         HREADY,
  output logic      [31:0]  HRDATA,
  output logic              HREADYOUT,
  output logic              HRESP,
  input  wire logic [7:0]   PIN_I,
  output pzm_pad_t          PAD,
  input  wire pzm_alt_out_t ALT_OUT,
  output pzm_alt_in_t       ALT_IN,
  output pzm_far_en_t       FAR_EN,
  output logic      [7:0]   CONV_CTRL,
  output logic      [7:0]   SER_CTRL
);
  // ----------------------------------------------------------------
  // Registers and bus
  // ----------------------------------------------------------------
  logic [7:0] data_q, data_d, dir_q, dir_d, od_q, od_d, pu_q, pu_d;
  logic [7:0] alt_a_q, alt_a_d, alt_b_q, alt_b_d;
  logic [7:0] conv_q, conv_d, ser_q, ser_d;
  logic [7:0] pin_s1_q, pin_s2_q;
  logic       wr_q;
  logic [7:0] wr_idx_q;
  logic       accept, addr_ok;
  logic [7:0] idx;

  // Stalls the bus while frozen, so no phase is lost
  assign HREADYOUT = CE;
  assign HRESP     = 1'b0;

  assign accept  = CE & HREADY & HSEL & HTRANS[1];
  assign addr_ok = (HADDR[31:10] == 22'h0) & (HADDR[1:0] == 2'b00);
  assign idx     = HADDR[9:2];

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_q     <= 1'b0;
      wr_idx_q <= 8'h00;
    end else if (CE) begin
      wr_q     <= accept & HWRITE & addr_ok;
      wr_idx_q <= idx;
    end
  end

  // Next values; reads see a write still in its data phase
  always_comb begin
    data_d  = data_q;
    dir_d   = dir_q;
    od_d    = od_q;
    pu_d    = pu_q;
    alt_a_d = alt_a_q;
    alt_b_d = alt_b_q;
    conv_d  = conv_q;
    ser_d   = ser_q;
    if (wr_q) begin
      case (wr_idx_q)
        `PZM_IDX_DATA:  data_d  = HWDATA[7:0];
        `PZM_IDX_DIR:   dir_d   = HWDATA[7:0];
        `PZM_IDX_OD:    od_d    = HWDATA[7:0];
        `PZM_IDX_PU:    pu_d    = HWDATA[7:0];
        `PZM_IDX_ALT_A: alt_a_d = HWDATA[7:0];
        `PZM_IDX_ALT_B: alt_b_d = {4'h0, HWDATA[3:0]};
        `PZM_IDX_CONV:  conv_d  = HWDATA[7:0];
        `PZM_IDX_SER:   ser_d   = HWDATA[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dir_q <= `PZM_RST_DIR;
    end else if (CE) begin
      dir_q <= dir_d;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      data_q <= `PZM_RST_DATA;
    end else if (CE) begin
      data_q <= data_d;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      od_q    <= `PZM_RST_OTHER;
      pu_q    <= `PZM_RST_OTHER;
      alt_a_q <= `PZM_RST_OTHER;
      alt_b_q <= `PZM_RST_OTHER;
      conv_q  <= `PZM_RST_OTHER;
      ser_q   <= `PZM_RST_OTHER;
    end else if (CE) begin
      od_q    <= od_d;
      pu_q    <= pu_d;
      alt_a_q <= alt_a_d;
      alt_b_q <= alt_b_d;
      conv_q  <= conv_d;
      ser_q   <= ser_d;
    end
  end

  // Pins are asynchronous to the system clock
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else if (CE) begin
      pin_s1_q <= PIN_I;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------
  logic       conv_on, ser_on, ser_tx, ser_rx, sclk_ext;
  logic [3:0] conv_ch;
  logic [7:0] analog, alt_in, alt_drv, alt_val, gpio_mask;
  logic [7:0] eff_oe, eff_val;

  assign conv_on  = conv_q[`PZM_CONV_EN];
  assign conv_ch  = conv_q[`PZM_CONV_CH_HI:`PZM_CONV_CH_LO];
  assign ser_tx   = ser_q[`PZM_SER_MODE_LO];
  assign ser_rx   = ser_q[`PZM_SER_MODE_HI];
  assign ser_on   = ser_tx | ser_rx;
  assign sclk_ext = &ser_q[`PZM_SER_CLK_HI:`PZM_SER_CLK_LO];

  always_comb begin
    analog = 8'h00;
    if (conv_on) begin
      case (conv_ch)
        4'h1: analog[1] = 1'b1;
        4'h3: analog[3] = 1'b1;
        4'h4: analog[4] = 1'b1;
        4'h5: analog[5] = 1'b1;
        4'h6: analog[6] = 1'b1;
        4'h7: analog[7] = 1'b1;
        default: ;
      endcase
    end
  end

  always_comb begin
    alt_in  = 8'h00;
    alt_drv = 8'h00;
    alt_val = 8'h00;
    // interrupt three wins over serial clock
    alt_in[0]  = alt_a_q[`PZM_A_EXT_INTERRUPT_THREE] | (ser_on & sclk_ext);
    alt_drv[0] = ~alt_a_q[`PZM_A_EXT_INTERRUPT_THREE] & ser_on & ~sclk_ext;
    alt_val[0] = ALT_OUT.serial_clk;
    alt_in[1]  = ser_rx;
    alt_drv[2] = ser_tx;
    alt_val[2] = ALT_OUT.serial_data;
    alt_in[3]  = alt_a_q[`PZM_A_EXT_INTERRUPT_TWO];
    alt_in[4]  = alt_a_q[`PZM_A_EC0];
    alt_drv[5] = alt_b_q[`PZM_B_T0O];
    alt_val[5] = ALT_OUT.timer_a;
    alt_drv[6] = alt_b_q[`PZM_B_T2O];
    alt_val[6] = ALT_OUT.timer_c;
    alt_in[7]  = alt_a_q[`PZM_A_EC1];
  end

  assign gpio_mask = ~(analog | alt_in | alt_drv);

  assign eff_oe  = ~analog & (alt_drv | (~alt_in & dir_q));
  assign eff_val = (alt_drv & alt_val) | (~alt_drv & data_q);

  // ----------------------------------------------------------------
  // Pad controls
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PAD <= '0;
    end else if (CE) begin
      PAD.o   <= eff_val & ~od_q;
      PAD.oe  <= eff_oe & (~od_q | ~eff_val);
      PAD.pu  <= pu_q & ~eff_oe & ~analog;
      PAD.ana <= analog;
    end
  end

  // Inputs read zero when not selected
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ALT_IN <= '0;
    end else if (CE) begin
      ALT_IN.ext_int_three <= alt_a_q[`PZM_A_EXT_INTERRUPT_THREE] & pin_s2_q[0];
      ALT_IN.ext_int_two   <= alt_a_q[`PZM_A_EXT_INTERRUPT_TWO] & pin_s2_q[3];
      ALT_IN.event_count_a <= alt_a_q[`PZM_A_EC0] & pin_s2_q[4];
      ALT_IN.event_count_b <= alt_a_q[`PZM_A_EC1] & pin_s2_q[7];
      ALT_IN.serial_clk    <= ser_on & sclk_ext & pin_s2_q[0];
      ALT_IN.serial_data   <= ser_rx & pin_s2_q[1];
    end
  end

  assign FAR_EN.pwm_c_output_enable  = alt_a_q[7];
  assign FAR_EN.pwm_a_output_enable  = alt_a_q[6];
  assign FAR_EN.crystal_pin_enable   = alt_b_q[3];
  assign FAR_EN.buzzer_output_enable = alt_b_q[2];
  assign CONV_CTRL = conv_q;
  assign SER_CTRL  = ser_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_val;

  always_comb begin
    rd_val = 8'h00;
    if (addr_ok) begin
      case (idx)
        `PZM_IDX_DATA:  rd_val = (eff_oe & data_d) | (~eff_oe & pin_s2_q);
        `PZM_IDX_DIR:   rd_val = dir_d;
        `PZM_IDX_OD:    rd_val = od_d;
        `PZM_IDX_PU:    rd_val = pu_d;
        `PZM_IDX_ALT_A: rd_val = alt_a_d;
        `PZM_IDX_ALT_B: rd_val = alt_b_d;
        `PZM_IDX_CONV:  rd_val = conv_d;
        `PZM_IDX_SER:   rd_val = ser_d;
        default:        rd_val = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      HRDATA <= 32'h0000_0000;
    end else if (accept & ~HWRITE) begin
      HRDATA <= {24'h00_0000, rd_val};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  a_dir_input: assert property (CE |=> (PAD.oe & $past(gpio_mask & ~dir_q)) == 8'h00)
    else $error("input pin is driven");
  a_dir_output: assert property (CE |=> ((PAD.o ^ $past(data_q & ~od_q)) & $past(gpio_mask & dir_q)) == 8'h00)
    else $error("output pin misses latch value");
  a_dir_reset: assert property (!$past(RST_B) |-> dir_q == 8'h00)
    else $error("direction not cleared by reset");
  a_pullup_gate: assert property (CE |=> PAD.pu == $past(pu_q & ~eff_oe & ~analog))
    else $error("pull-up wrong for pin state");
  a_open_drain: assert property (CE |=> (PAD.o & $past(od_q)) == 8'h00)
    else $error("open-drain pin drives high");
  a_ext_interrupt_three_owns: assert property (CE && alt_a_q[`PZM_A_EXT_INTERRUPT_THREE] |=> !PAD.oe[0])
    else $error("interrupt pin still driven");
  a_timer_a_pin: assert property (CE && alt_b_q[`PZM_B_T0O] && !analog[5] && !od_q[5]
                                  |=> PAD.oe[5] && PAD.o[5] == $past(ALT_OUT.timer_a))
    else $error("timer output not on pin five");
  a_serial_out: assert property (CE && ser_tx && !od_q[2] |=> PAD.o[2] == $past(ALT_OUT.serial_data))
    else $error("serial data not on pin two");
  a_analog_own: assert property (CE |=> PAD.ana == $past(analog) && (PAD.oe & PAD.ana) == 8'h00)
    else $error("analog pin misconfigured");
  a_ext_interrupt_two_pass: assert property (CE && alt_a_q[`PZM_A_EXT_INTERRUPT_TWO] |=> ALT_IN.ext_int_two == $past(pin_s2_q[3]))
    else $error("interrupt two not passed");
  a_dir_read: assert property (accept && !HWRITE && addr_ok && idx == `PZM_IDX_DIR
                               |=> HRDATA == {24'h00_0000, dir_q})
    else $error("direction read back wrong");
  a_bus_okay: assert property (HRESP == 1'b0)
    else $error("response not okay");

endmodule : pzm_port

// file: pzm_pins.sv
/*
 * Board model at the pins of port zero: pad drive, pull-up, outside driver.
 * Assumes pad outputs on the system clock; a floating pin toggles every cycle.
 */
`timescale 1ns/1ps
module pzm_pins
  import pzm_pkg::*;
(
  input  wire logic       clk,
  input  wire pzm_pad_t   pad,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin
);
  // Floating pins must not look like a stable level
  logic [7:0] flt_q = 8'h55;
  always_ff @(posedge clk) begin
    flt_q <= ~flt_q;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.oe[i]) begin
        pin[i] = pad.o[i];
      end else if (ext_en[i]) begin
        pin[i] = ext_val[i];
      end else if (pad.pu[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = flt_q[i];
      end
    end
  end
endmodule : pzm_pins

// file: pzm_port_test.sv
/*
 * Self-checking testbench of port zero, one task per scenario.
 * Assumes pzm_defs.svh indices and a zero-wait AHB-Lite slave.
 */
`timescale 1ns/1ps
`include "pzm_defs.svh"
module pzm_port_test
  import pzm_pkg::*;
;
  logic         clk, rst_b, hsel, hwrite;
  logic [1:0]   htrans;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic         hreadyout, hresp;
  logic [7:0]   pin_i, ext_en, ext_val, conv_ctrl, ser_ctrl;
  pzm_pad_t     pad;
  pzm_alt_out_t alt_out;
  pzm_alt_in_t  alt_in;
  pzm_far_en_t  far_en;
  int           n_errors, compares;

  pzm_port uut (.SYS_CLK(clk), .RST_B(rst_b), .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PIN_I(pin_i), .PAD(pad), .ALT_OUT(alt_out),
    .ALT_IN(alt_in), .FAR_EN(far_en), .CONV_CTRL(conv_ctrl), .SER_CTRL(ser_ctrl));
  pzm_pins pins (.clk(clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin(pin_i));

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {22'h0, idx, 2'b00}; hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // Two sync flops plus registered pads need a few edges
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    bus(0, `PZM_IDX_DIR, 8'h0); chk(rd, 0);
    chk(pad.oe, 0);
    bus(0, 8'h10, 8'h0); chk(rd, 0);
    chk(hresp, 0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_dir();
    bus(1, `PZM_IDX_DATA, 8'ha5); bus(1, `PZM_IDX_DIR, 8'h0f);
    ext_en <= 8'hf0; ext_val <= 8'h30; settle();
    chk(pad.oe, 8'h0f);
    chk(pad.o[3:0], 4'h5);
    bus(0, `PZM_IDX_DATA, 8'h0); chk(rd, 8'h35);
    bus(0, `PZM_IDX_DIR, 8'h0); chk(rd, 8'h0f);
    bus(1, `PZM_IDX_PU, 8'hff); ext_en <= 8'h00; settle();
    chk(pad.pu, 8'hf0);
    bus(0, `PZM_IDX_DATA, 8'h0); chk(rd, 8'hf5);
    $display("test direction done");
  endtask : t_dir
  task automatic t_od();
    bus(1, `PZM_IDX_OD, 8'hff); settle();
    chk(pad.oe, 8'h0a);
    chk(pad.o[3:0], 4'h0);
    bus(1, `PZM_IDX_OD, 8'h00); bus(1, `PZM_IDX_PU, 8'h00);
    $display("test open drain done");
  endtask : t_od
  task automatic t_alt();
    bus(1, `PZM_IDX_DIR, 8'hff); bus(1, `PZM_IDX_ALT_A, 8'hfc); bus(1, `PZM_IDX_ALT_B, 8'h0f);
    ext_en <= 8'h99; ext_val <= 8'h99; alt_out <= 4'b0100; settle();
    chk(pad.oe, 8'h66);
    chk({pad.o[6], pad.o[5]}, 2'b10);
    chk({alt_in.ext_int_three, alt_in.ext_int_two}, 2'b11);
    chk({alt_in.event_count_a, alt_in.event_count_b}, 2'b11);
    chk(far_en, 4'hf);
    bus(0, `PZM_IDX_ALT_A, 8'h0); chk(rd, 8'hfc);
    bus(1, `PZM_IDX_ALT_A, 8'h00); bus(1, `PZM_IDX_ALT_B, 8'h00);
    $display("test alternates done");
  endtask : t_alt
  task automatic t_conv();
    int ch[6] = '{1, 3, 4, 5, 6, 7};
    foreach (ch[k]) begin
      bus(1, `PZM_IDX_CONV, 8'h80 | 8'(ch[k] << 2)); settle();
      chk(pad.ana, 8'h1 << ch[k]);
      chk(conv_ctrl, 8'h80 | 8'(ch[k] << 2));
    end
    bus(1, `PZM_IDX_CONV, 8'h00);
    $display("test converter done");
  endtask : t_conv
  task automatic t_serial();
    alt_out <= 4'b0000; bus(1, `PZM_IDX_SER, 8'h10); settle();
    chk({pad.o[2], pad.o[0]}, 2'b00);
    bus(1, `PZM_IDX_SER, 8'h2c); ext_en <= 8'h03; ext_val <= 8'h03; settle();
    chk(ser_ctrl, 8'h2c);
    chk(pad.oe[1:0], 2'b00);
    chk({alt_in.serial_clk, alt_in.serial_data}, 2'b11);
    $display("test serial done");
  endtask : t_serial

  // ----------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    rst_b = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'b00; haddr = 0; hwdata = 0;
    ext_en = 8'h00; ext_val = 8'h00; alt_out = 4'b0000; n_errors = 0; compares = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_dir();
    t_od();
    t_alt();
    t_conv();
    t_serial();
    print_verdict();
  end
endmodule : pzm_port_test
